// *** logic/vco_cal_bank.sv ***
// Purpose: serial-port register bank for vco calibration and test
// Assumes: spi pins and pfd clock are asynchronous and slower than clk/4
// Notes: frame is r/w flag, 15-bit address, 8 data bits, msb first
`timescale 1ns/1ps

// Contract
// - timeout top bits in adc control bits 1:0
// - adc enable overrides adc clock disable
// - synthetic lock wait 5 bits, resets 0xc
// - bias loop settle wait 5 bits, resets 0x1e
// - adc clock is pfd over 4*div+2
// - one-hot test core pick in bits 7:4
// - test bias code in bits 3:0
// - 8-bit test band select, resets zero
// - 4-bit tune target code, resets 0x7
// - 8-bit adc offset correction, resets 0x55
// - pump test: zero tristates, 11 normal
// - open-loop count readable as two bytes
// - mixer source bit picks divided or fundamental
// - mixer path power field bits 5:4
// - prescale bit divides lock count by 32
// - lock detect readback in bit 0 only
// - conversion starts on address zero write
// - lock count select decodes 1024 to 8192
module vco_cal_bank #(
   parameter int DIV_W = 8
) (
   // clock, reset, freeze
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // serial port pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   // pfd rate clock pin for the adc clock divider
   input wire logic pfd_clk,
   // status and fields from the rest of the device
   input wire logic [7:0] timeout_low,
   input wire logic [1:0] lock_count_select,
   input wire logic [15:0] open_loop_count_value,
   input wire logic cal_lock,
   // controls to the analog side
   output vco_cal_pkg::cal_ctl_s cal_ctl,
   output vco_cal_pkg::test_ctl_s test_ctl,
   output logic adc_clk_out,
   output logic adc_conv_start,
   output logic mixer_source_select,
   output logic [1:0] mixer_path_power,
   output logic internal_buffer_on,
   output logic feedback_divider_off,
   output logic [13:0] lock_count_cycles
);

   ////////////////////////////////////////////////////////////////////
   // helpers

   // read decode of one address; unmapped reads zero
   // later cases win, so read-only places override the table
   function automatic logic [7:0] rd_val(
      input logic [14:0] a,
      input logic [7:0] regs [vco_cal_pkg::NREG],
      input logic [15:0] cnt,
      input logic lk);
      logic [7:0] v;
      v = 8'h00;
      for (int i = 0; i < vco_cal_pkg::NREG; i++) begin
         if (a == vco_cal_pkg::REG_ADDR[i]) begin
            v = regs[i];
         end
      end
      case (a)
         vco_cal_pkg::A_RSV_RO_A: v = vco_cal_pkg::RSV_RO_A_VAL;
         vco_cal_pkg::A_RSV_RO_B: v = vco_cal_pkg::RSV_RO_B_VAL;
         vco_cal_pkg::A_RSV_RO_C: v = vco_cal_pkg::RSV_RO_C_VAL;
         vco_cal_pkg::A_CNT_LO: v = cnt[7:0];
         vco_cal_pkg::A_CNT_HI: v = cnt[15:8];
         vco_cal_pkg::A_LOCK_ST: v = {7'h00, lk};
         default: v = v;
      endcase
      return v;
   endfunction : rd_val

   // header address: fourteen held bits plus the one arriving now
   function automatic logic [14:0] hdr_addr(
      input logic [22:0] sh,
      input logic b);
      return {sh[13:0], b};
   endfunction : hdr_addr

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers

   // two flops per pin; third stage only for edge detection
   logic [3:0] sync1_r; // first stage, read by stage two only
   logic [3:0] sync2_r; // settled pin levels
   logic sclk_d_r; // previous settled sclk
   logic pfd_d_r; // previous settled pfd clock

   // pins: 3 pfd, 2 sclk, 1 cs_n, 0 sdi
   // cs_n resets high so release cannot look like a frame start
   // sdi shares sclk's delay, so a detected rise sees settled data
   // rst wins over ce, so a frozen block can still be reset
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_r <= 4'h2;
         sync2_r <= 4'h2;
         sclk_d_r <= 1'b0;
         pfd_d_r <= 1'b0;
      end else if (ce) begin
         sync1_r <= {pfd_clk, sclk, cs_n, sdi};
         sync2_r <= sync1_r;
         sclk_d_r <= sync2_r[2];
         pfd_d_r <= sync2_r[3];
      end
   end

   logic sclk_rise; // settled sclk rising
   logic sclk_fall; // settled sclk falling
   logic pfd_rise; // one pfd period has passed
   logic sel; // frame in progress
   assign sclk_rise = sync2_r[2] & ~sclk_d_r;
   assign sclk_fall = ~sync2_r[2] & sclk_d_r;
   assign pfd_rise = sync2_r[3] & ~pfd_d_r;
   assign sel = ~sync2_r[1];

   ////////////////////////////////////////////////////////////////////
   // serial frame receiver

   logic [22:0] sh_r; // bits received so far
   logic [4:0] bit_r; // index of the next bit
   logic [14:0] addr_r; // address captured from the header
   logic rd_r; // frame is a read
   logic wr_nxt; // last data bit of a write arrives now
   assign wr_nxt = sel & sclk_rise & ~rd_r
      & (bit_r == vco_cal_pkg::FRM_LAST);

   // shift in on sclk rising; deselect restarts the frame
   // a frame cut short never reaches its last slot and writes nothing
   always_ff @(posedge clk) begin
      if (rst) begin
         sh_r <= '0;
         bit_r <= '0;
         addr_r <= '0;
         rd_r <= 1'b0;
      end else if (ce) begin
         if (!sel) begin
            bit_r <= '0;
            rd_r <= 1'b0;
         end else if (sclk_rise) begin
            sh_r <= {sh_r[21:0], sync2_r[0]};
            // extra clocks past the frame are ignored
            // bit_r parks one past the last slot
            if (bit_r != vco_cal_pkg::FRM_LAST + 5'h01) begin
               bit_r <= bit_r + 5'h01;
            end
            if (bit_r == vco_cal_pkg::HDR_LAST) begin
               addr_r <= hdr_addr(sh_r, sync2_r[0]);
               rd_r <= sh_r[14];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register storage

   logic [7:0] regs_r [vco_cal_pkg::NREG]; // writable registers
   logic [7:0] wdata; // byte being written
   assign wdata = {sh_r[6:0], sync2_r[0]};

   // masked write keeps read-only bits at their defaults
   // a read frame never reaches this path, so reads change nothing
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < vco_cal_pkg::NREG; i++) begin
            regs_r[i] <= vco_cal_pkg::REG_RST[i];
         end
      end else if (ce && wr_nxt) begin
         for (int i = 0; i < vco_cal_pkg::NREG; i++) begin
            if (addr_r == vco_cal_pkg::REG_ADDR[i]) begin
               regs_r[i] <= (regs_r[i] & ~vco_cal_pkg::REG_WMASK[i])
                  | (wdata & vco_cal_pkg::REG_WMASK[i]);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // readback of internal status

   logic [15:0] count_r; // open-loop count image
   logic lock_r; // calibration lock image

   // no write path reaches these
   // the count bytes come from two frames and are not latched together;
   // software wanting a whole value reads twice and compares
   // these inputs share clk, so one flop suffices
   always_ff @(posedge clk) begin
      if (rst) begin
         count_r <= '0;
         lock_r <= 1'b0;
      end else if (ce) begin
         count_r <= open_loop_count_value;
         lock_r <= cal_lock;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // serial read data

   logic [7:0] rsh_r; // read byte being shifted out
   logic sdo_r; // serial data output
   logic oe_r; // serial output driven

   // read byte is captured once the header ends, so a value that
   // changes mid-frame cannot tear the byte on the wire
   // sdo parks low when deselected rather than holding its last bit
   always_ff @(posedge clk) begin
      if (rst) begin
         rsh_r <= '0;
         sdo_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (ce) begin
         if (!sel) begin
            oe_r <= 1'b0;
            sdo_r <= 1'b0;
         end else if (rd_r && sclk_fall
            && bit_r >= vco_cal_pkg::DAT_FIRST
            && bit_r <= vco_cal_pkg::FRM_LAST) begin
            // present one bit per falling edge, msb first
            sdo_r <= rsh_r[7];
            rsh_r <= {rsh_r[6:0], 1'b0};
            oe_r <= 1'b1;
         end else if (sclk_rise && bit_r == vco_cal_pkg::HDR_LAST) begin
            rsh_r <= rd_val(hdr_addr(sh_r, sync2_r[0]), regs_r,
               count_r, lock_r);
         end
      end
   end

   assign sdo = sdo_r;
   assign sdo_oe = oe_r;

   ////////////////////////////////////////////////////////////////////
   // adc conversion trigger

   logic conv_r; // one-cycle conversion start

   // address zero write arms it only with both bits set
   // the enable bits are those already stored, not this frame's data
   // a read frame never raises wr_nxt, so reads cannot convert
   always_ff @(posedge clk) begin
      if (rst) begin
         conv_r <= 1'b0;
      end else if (ce) begin
         conv_r <= wr_nxt && addr_r == vco_cal_pkg::A_CONV_TRIG
            && regs_r[vco_cal_pkg::I_ADC_CTL][vco_cal_pkg::B_ADC_CONV]
            && regs_r[vco_cal_pkg::I_ADC_CTL][vco_cal_pkg::B_ADC_EN];
      end
   end

   assign adc_conv_start = conv_r;

   ////////////////////////////////////////////////////////////////////
   // adc clock divider

   logic [DIV_W:0] half_cnt_r; // pfd edges in this half period
   logic [DIV_W:0] half_len; // pfd edges per half period
   logic adc_clk_r; // divided clock
   logic adc_run; // divider allowed to run
   // full period 4*div+2 pfd cycles, so each half is 2*div+1
   assign half_len = {regs_r[vco_cal_pkg::I_ADC_DIV], 1'b1};
   // enable set wins over the clock disable bit
   assign adc_run = regs_r[vco_cal_pkg::I_ADC_CTL][vco_cal_pkg::B_ADC_EN]
      | ~regs_r[vco_cal_pkg::I_DIV_CTL][vco_cal_pkg::B_CLK_DIS];

   // toggles after half_len pfd edges; parks low when stopped
   // pfd edges are seen after synchronising, so the pfd clock must stay
   // below a quarter of clk or edges are lost
   // the >= test stops a shrunken divider from wrapping the count
   // stopping clears the count, so a restart runs a full half period
   always_ff @(posedge clk) begin
      if (rst) begin
         half_cnt_r <= '0;
         adc_clk_r <= 1'b0;
      end else if (ce) begin
         if (!adc_run) begin
            half_cnt_r <= '0;
            adc_clk_r <= 1'b0;
         end else if (pfd_rise) begin
            if (half_cnt_r >= half_len - 1'b1) begin
               half_cnt_r <= '0;
               adc_clk_r <= ~adc_clk_r;
            end else begin
               half_cnt_r <= half_cnt_r + 1'b1;
            end
         end
      end
   end

   assign adc_clk_out = adc_clk_r;

   ////////////////////////////////////////////////////////////////////
   // registered field outputs

   vco_cal_pkg::cal_ctl_s cal_r; // timing and trim fields
   vco_cal_pkg::test_ctl_s test_r; // test overrides
   logic mix_src_r; // mixer source
   logic [1:0] mix_pwr_r; // mixer path power
   logic buf_on_r; // internal buffer on
   logic fb_off_r; // feedback divider off
   logic [13:0] lock_cyc_r; // lock detector count
   logic [13:0] lock_full; // count before prescale
   assign lock_full = vco_cal_pkg::LOCK_BASE << lock_count_select;

   // fields are re-registered so every output comes from a flop
   // the extra cycle of latency keeps glitches off the analog controls
   always_ff @(posedge clk) begin
      if (rst) begin
         cal_r <= '0;
         test_r <= '0;
         mix_src_r <= 1'b0;
         mix_pwr_r <= '0;
         buf_on_r <= 1'b0;
         fb_off_r <= 1'b0;
         lock_cyc_r <= '0;
      end else if (ce) begin
         cal_r.cal_timeout <= {regs_r[vco_cal_pkg::I_ADC_CTL][1:0],
            timeout_low};
         cal_r.synthetic_lock_wait <= regs_r[vco_cal_pkg::I_SYN][4:0];
         cal_r.bias_loop_settle_wait <=
            regs_r[vco_cal_pkg::I_SETTLE][4:0];
         cal_r.adc_offset <= regs_r[vco_cal_pkg::I_ADC_OFS];
         cal_r.pump_current_trim <= regs_r[vco_cal_pkg::I_PUMP_OFS];
         test_r.core_pick <= regs_r[vco_cal_pkg::I_CORE][7:4];
         test_r.bias_code <= regs_r[vco_cal_pkg::I_CORE][3:0];
         test_r.band <= regs_r[vco_cal_pkg::I_BAND];
         test_r.tune_target <= regs_r[vco_cal_pkg::I_TUNE][3:0];
         // other pump codes are neither tristate nor normal
         test_r.pump_tristate <=
            regs_r[vco_cal_pkg::I_PUMP_TST][3:2] == 2'b00;
         test_r.pump_normal <=
            regs_r[vco_cal_pkg::I_PUMP_TST][3:2] == 2'b11;
         mix_src_r <= regs_r[vco_cal_pkg::I_MIX][vco_cal_pkg::B_MIX_SRC];
         mix_pwr_r <= regs_r[vco_cal_pkg::I_MIX][5:4];
         // passed through as written; clearing it is a user fault
         buf_on_r <= regs_r[vco_cal_pkg::I_MIX][vco_cal_pkg::B_BUF_ON];
         fb_off_r <=
            regs_r[vco_cal_pkg::I_DIV_CTL][vco_cal_pkg::B_FB_OFF];
         // prescaling divides the decoded count by 32
         if (regs_r[vco_cal_pkg::I_DIV_CTL][vco_cal_pkg::B_PRESCALE]) begin
            lock_cyc_r <= lock_full >> vco_cal_pkg::LOCK_PRE_SH;
         end else begin
            lock_cyc_r <= lock_full;
         end
      end
   end

   // ports are plain copies of flops, with no logic between
   assign cal_ctl = cal_r;
   assign test_ctl = test_r;
   assign mixer_source_select = mix_src_r;
   assign mixer_path_power = mix_pwr_r;
   assign internal_buffer_on = buf_on_r;
   assign feedback_divider_off = fb_off_r;
   assign lock_count_cycles = lock_cyc_r;

endmodule : vco_cal_bank

// *** inc/vco_cal_pkg.sv ***
// Purpose: constants and carriers for the calibration/test register bank
// Assumes: byte-wide registers reached over a 24-bit serial frame
// Notes: writable registers live in one table indexed by position
package vco_cal_pkg;

   // serial frame: read flag, 15-bit address, 8 data bits, msb first
   localparam int FRAME_W = 24;
   localparam int ADDR_W = 15;
   localparam logic [4:0] HDR_LAST = 5'h0f; // count at last header bit
   localparam logic [4:0] FRM_LAST = 5'h17; // count at last data bit
   localparam logic [4:0] DAT_FIRST = 5'h10; // first data bit slot

   // address that arms an adc conversion on write
   localparam logic [14:0] A_CONV_TRIG = 15'h0000;

   // writable (fully or partly) registers
   localparam int NREG = 14;
   localparam int I_ADC_CTL = 0;
   localparam int I_SYN = 1;
   localparam int I_SETTLE = 2;
   localparam int I_ADC_DIV = 3;
   localparam int I_PUMP_OFS = 4;
   localparam int I_BAND = 5;
   localparam int I_CORE = 6;
   localparam int I_TUNE = 7;
   localparam int I_ADC_OFS = 8;
   localparam int I_PUMP_TST = 9;
   localparam int I_MIX = 12;
   localparam int I_DIV_CTL = 13;
   localparam logic [14:0] REG_ADDR [NREG] = '{
      15'h0032, 15'h0033, 15'h0034, 15'h0035, 15'h0036, 15'h0037,
      15'h0038, 15'h0039, 15'h003a, 15'h003e, 15'h003f, 15'h0041,
      15'h0072, 15'h0073};
   // mixer path byte: high output power and buffer on out of reset
   localparam logic [7:0] REG_RST [NREG] = '{
      8'h04, 8'h0c, 8'h9e, 8'h4c, 8'h30, 8'h00, 8'h00,
      8'h07, 8'h55, 8'h0c, 8'h80, 8'h28, 8'h1a, 8'h00};
   // bits that a write may change; the rest keep their reset value
   localparam logic [7:0] REG_WMASK [NREG] = '{
      8'hbf, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'h7f, 8'hff, 8'h0c, 8'hff, 8'hff, 8'h78, 8'h07};

   // read-only registers
   localparam logic [14:0] A_RSV_RO_A = 15'h0040;
   localparam logic [14:0] A_RSV_RO_B = 15'h0047;
   localparam logic [14:0] A_RSV_RO_C = 15'h0052;
   localparam logic [14:0] A_CNT_LO = 15'h006e;
   localparam logic [14:0] A_CNT_HI = 15'h006f;
   localparam logic [14:0] A_LOCK_ST = 15'h007c;
   localparam logic [7:0] RSV_RO_A_VAL = 8'h50;
   localparam logic [7:0] RSV_RO_B_VAL = 8'hc0;
   localparam logic [7:0] RSV_RO_C_VAL = 8'hf4;

   // field positions
   localparam int B_ADC_EN = 2;
   localparam int B_ADC_CONV = 3;
   localparam int B_MIX_SRC = 6;
   localparam int B_BUF_ON = 3;
   localparam int B_PRESCALE = 0;
   localparam int B_CLK_DIS = 2;
   localparam int B_FB_OFF = 1;

   // lock detector counts
   localparam logic [13:0] LOCK_BASE = 14'h0400; // 1024 pfd cycles
   localparam int LOCK_PRE_SH = 5; // divide by 32

   // test overrides to the vco core
   typedef struct packed {
      logic [3:0] core_pick;
      logic [3:0] bias_code;
      logic [7:0] band;
      logic [3:0] tune_target;
      logic pump_tristate;
      logic pump_normal;
   } test_ctl_s;

   // calibration timing and adc trims
   typedef struct packed {
      logic [9:0] cal_timeout;
      logic [4:0] synthetic_lock_wait;
      logic [4:0] bias_loop_settle_wait;
      logic [7:0] adc_offset;
      logic [7:0] pump_current_trim;
   } cal_ctl_s;

endpackage : vco_cal_pkg

// *** verif/vco_cal_bank_sva.sv ***
// Purpose: port-level checker for the calibration/test register bank
// Assumes: one clock domain, ce held high by the bench
// Notes: register contents are hidden, so checks tie outputs to pins
`timescale 1ns/1ps
module vco_cal_bank_sva #(
   parameter int DIV_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial pins
   input wire logic cs_n,
   input wire logic sdo,
   input wire logic sdo_oe,
   // status inputs
   input wire logic [7:0] timeout_low,
   input wire logic [1:0] lock_count_select,
   // controls out
   input wire vco_cal_pkg::cal_ctl_s cal_ctl,
   input wire vco_cal_pkg::test_ctl_s test_ctl,
   input wire logic adc_conv_start,
   input wire logic mixer_source_select,
   input wire logic [1:0] mixer_path_power,
   input wire logic internal_buffer_on,
   input wire logic [13:0] lock_count_cycles
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // cycles since release; outputs lag reset by a few edges
   logic [1:0] up_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         up_r <= 2'h0;
      end else if (up_r != 2'h3) begin
         up_r <= up_r + 2'h1;
      end
   end
   ////////////////////////////////////////
   AST_RST_TEST: assert property ($fell(rst) |-> ##3
      test_ctl == {16'h0000, 4'h7, 2'b01})
      else $error("test controls not at reset values");
   AST_RST_CAL: assert property ($fell(rst) |-> ##3
      cal_ctl[25:0] == {5'h0c, 5'h1e, 8'h55, 8'h30})
      else $error("calibration fields not at reset values");
   AST_RST_MIX: assert property ($fell(rst) |-> ##3
      {mixer_source_select, mixer_path_power, internal_buffer_on} == 4'h3)
      else $error("mixer path fields not at reset values");
   // latency of up to three edges is allowed for the low timeout byte
   AST_TIMEOUT_LOW: assert property ((up_r == 2'h3 &&
      $stable(timeout_low)) [*3] |-> cal_ctl.cal_timeout[7:0] == timeout_low)
      else $error("timeout low byte not passed through");
   AST_LOCK_DECODE: assert property ((up_r == 2'h3 &&
      $stable(lock_count_select)) [*3] |-> lock_count_cycles inside
      {14'h0400 << lock_count_select, (14'h0400 << lock_count_select) >> 5})
      else $error("lock count decode wrong");
   AST_PUMP_EXCL: assert property (
      !(test_ctl.pump_tristate && test_ctl.pump_normal))
      else $error("pump tristate and normal both set");
   AST_CONV_PULSE: assert property (adc_conv_start |=> !adc_conv_start)
      else $error("conversion start longer than one cycle");
   AST_CONV_WRITE: assert property (adc_conv_start |-> !sdo_oe)
      else $error("conversion start during a read");
   AST_SDO_IDLE: assert property (cs_n [*5] |-> !sdo_oe && !sdo)
      else $error("serial output driven while deselected");
   // main scenarios reached
   cover property (adc_conv_start);
   cover property ($rose(sdo_oe));
   cover property (lock_count_cycles == 14'h0020);
endmodule : vco_cal_bank_sva
bind vco_cal_bank vco_cal_bank_sva #(.DIV_W(DIV_W)) sva_u (.clk(clk),
   .rst(rst), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe),
   .timeout_low(timeout_low), .lock_count_select(lock_count_select),
   .cal_ctl(cal_ctl), .test_ctl(test_ctl), .adc_conv_start(adc_conv_start),
   .mixer_source_select(mixer_source_select),
   .mixer_path_power(mixer_path_power),
   .internal_buffer_on(internal_buffer_on),
   .lock_count_cycles(lock_count_cycles));

// *** verif/vco_cal_host.sv ***
// Purpose: serial host model driving frames into the register bank
// Assumes: pins move on falling clk, sclk half period of four clocks
// Notes: sclk stands low between frames, sdi inverted once deselected
`timescale 1ns/1ps
module vco_cal_host (
   // bench clock
   input wire logic clk,
   // serial pins
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo
);
   // idle pins at time zero
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   ////////////////////////////////////////
   // one frame: flag, 15-bit address, data byte, msb first
   task automatic xfer(input logic rd, input logic [14:0] a,
      input logic [7:0] d, output logic [7:0] q);
      logic [23:0] f;
      f = {rd, a, d};
      q = 8'h00;
      @(negedge clk);
      cs_n = 1'b0;
      for (int i = 0; i < 24; i++) begin
         sclk = 1'b0;
         sdi = f[23 - i];
         repeat (4) @(negedge clk);
         // read data settles during the low half, taken before rising
         if (i >= 16) begin
            q = {q[6:0], sdo};
         end
         sclk = 1'b1;
         repeat (4) @(negedge clk);
      end
      sclk = 1'b0;
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      sdi = ~sdi;
      repeat (6) @(negedge clk);
   endtask : xfer
endmodule : vco_cal_host

// *** verif/vco_cal_bank_test.sv ***
// Purpose: self-checking bench for the calibration/test register bank
// Assumes: ce held high; inputs move on the falling clock edge
// Notes: reference model keeps byte images keyed by address
`timescale 1ns/1ps
module vco_cal_bank_test;
   // design pins
   logic clk, rst, ce, sclk, cs_n, sdi, sdo, sdo_oe, pfd_clk, cal_lock;
   logic adc_clk_out, adc_conv_start, mixer_source_select;
   logic internal_buffer_on, feedback_divider_off;
   logic [1:0] lock_count_select, mixer_path_power;
   logic [7:0] timeout_low, q;
   logic [15:0] open_loop_count_value;
   logic [13:0] lock_count_cycles;
   vco_cal_pkg::cal_ctl_s cal_ctl;
   vco_cal_pkg::test_ctl_s test_ctl;
   // bench state
   int miscompares, checks, pulses, pfd_n, gap, tog, seed;
   logic [7:0] mdl [int];
   // address, reset value, writable bits (zero means read-only)
   logic [23:0] tbl [20] = '{24'h3204bf, 24'h330c1f, 24'h349eff,
      24'h354cff, 24'h3630ff, 24'h3700ff, 24'h3800ff, 24'h39077f,
      24'h3a55ff, 24'h3e0c0c, 24'h3f80ff, 24'h405000, 24'h4128ff,
      24'h47c000, 24'h52f400, 24'h6e0000, 24'h6f0000, 24'h721a78,
      24'h730007, 24'h7c0000};
   vco_cal_bank #(.DIV_W(8)) DUT (.clk, .rst, .ce, .sclk, .cs_n, .sdi,
      .sdo, .sdo_oe, .pfd_clk, .timeout_low, .lock_count_select,
      .open_loop_count_value, .cal_lock, .cal_ctl, .test_ctl,
      .adc_clk_out, .adc_conv_start, .mixer_source_select,
      .mixer_path_power, .internal_buffer_on, .feedback_divider_off,
      .lock_count_cycles);
   vco_cal_host host (.clk, .sclk, .cs_n, .sdi, .sdo);
   ////////////////////////////////////////
   // 250 MHz clock; pfd clock of seven periods, off the clk edges
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      pfd_clk = 1'b0;
      #1;
      forever #14 pfd_clk = ~pfd_clk;
   end
   // count conversion pulses and pfd edges per adc clock half period
   always @(negedge clk) if (adc_conv_start === 1'b1) pulses++;
   always @(posedge pfd_clk) pfd_n++;
   always @(adc_clk_out) begin
      gap = pfd_n;
      pfd_n = 0;
      tog++;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [39:0] s, input logic [39:0] e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // readback places follow live status, unmapped reads give zero
   function automatic logic [7:0] rexp(input logic [7:0] a);
      case (a)
         8'h6e: return open_loop_count_value[7:0];
         8'h6f: return open_loop_count_value[15:8];
         8'h7c: return {7'h00, cal_lock};
         default: return mdl.exists(a) ? mdl[a] : 8'h00;
      endcase
   endfunction : rexp
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a == 8'h72) d[3] = 1'b1;
      host.xfer(1'b0, {7'h00, a}, d, q);
      foreach (tbl[j])
         if (tbl[j][23:16] == a)
            mdl[a] = (mdl[a] & ~tbl[j][7:0]) | (d & tbl[j][7:0]);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      host.xfer(1'b1, {7'h00, a}, 8'h00, q);
      chk(q, rexp(a));
   endtask : rd
   // every registered field output against the model
   task automatic outs;
      logic [13:0] lk;
      logic [35:0] cx;
      logic [21:0] tx;
      lk = 14'h0400 << lock_count_select;
      if (mdl[8'h73][0]) lk = lk >> 5;
      cx = {mdl[8'h32][1:0], timeout_low, mdl[8'h33][4:0], mdl[8'h34][4:0],
         mdl[8'h3a], mdl[8'h36]};
      tx = {mdl[8'h38], mdl[8'h37], mdl[8'h39][3:0],
         mdl[8'h3e][3:2] == 2'h0, mdl[8'h3e][3:2] == 2'h3};
      chk(cal_ctl, cx);
      chk(test_ctl, tx);
      chk({mixer_source_select, mixer_path_power}, mdl[8'h72][6:4]);
      chk(internal_buffer_on, mdl[8'h72][3]);
      chk({feedback_divider_off, lock_count_cycles},
         {mdl[8'h73][1], lk});
   endtask : outs
   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////
   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      seed = 32'ha589edf0;
      {miscompares, checks, pulses, pfd_n, gap, tog} = '0;
      rst = 1'b1;
      ce = 1'b1;
      timeout_low = 8'ha7;
      lock_count_select = 2'h1;
      open_loop_count_value = 16'h0000;
      cal_lock = 1'b0;
      foreach (tbl[j]) mdl[tbl[j][23:16]] = tbl[j][15:8];
      repeat (6) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (8) @(negedge clk);
      foreach (tbl[j]) rd(tbl[j][23:16]);
      outs();
      $display("reset values done");
      // random bytes everywhere; read-only places must not move
      for (int n = 0; n < 3; n++) begin
         @(negedge clk);
         timeout_low = 8'($random(seed));
         lock_count_select = 2'($random(seed));
         open_loop_count_value = 16'($random(seed));
         cal_lock = 1'($random(seed));
         foreach (tbl[j]) wr(tbl[j][23:16], 8'($random(seed)));
         wr(8'h50, 8'($random(seed)));
         foreach (tbl[j]) rd(tbl[j][23:16]);
         rd(8'h50);
         outs();
      end
      $display("random traffic done");
      // every lock count code with and without the prescaler
      for (int k = 0; k < 8; k++) begin
         @(negedge clk) lock_count_select = 2'(k);
         wr(8'h73, 8'(k >> 2));
         outs();
      end
      $display("lock count done");
      // conversion needs both enable bits; one missing gives none
      wr(8'h32, 8'h0c);
      pulses = 0;
      wr(8'h00, 8'h00);
      chk(pulses, 1);
      for (int k = 0; k < 2; k++) begin
         wr(8'h32, k ? 8'h08 : 8'h04);
         wr(8'h00, 8'h00);
         chk(pulses, 1);
      end
      $display("conversion trigger done");
      // divider of one; clock-disable set but adc enable wins
      wr(8'h73, 8'h04);
      wr(8'h32, 8'h04);
      wr(8'h35, 8'h01);
      repeat (4000) @(negedge clk);
      tog = 0;
      repeat (100) @(negedge clk);
      chk(gap, 3);
      chk(tog > 3, 1);
      wr(8'h32, 8'h00);
      repeat (50) @(negedge clk);
      tog = 0;
      repeat (100) @(negedge clk);
      chk(tog, 0);
      $display("adc clock done");
      tally_and_finish();
   end
endmodule : vco_cal_bank_test
